// ### rfs_device.sv
// regulator fault supervisor, device end
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module rfs_device (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  rfs_if.dev                       link,
  input  wire rfs_pkg::rfs_regv_t  ovIn,
  input  wire rfs_pkg::rfs_regv_t  uvIn,
  input  wire rfs_pkg::rfs_regv_t  ilimIn,
  input  wire rfs_pkg::rfs_regv_t  pgIn,
  input  wire logic                seqStart,
  input  wire logic                sysOn,
  input  wire rfs_pkg::rfs_regv_t  seqEnable,
  input  wire logic                atReleasePoint,
  input  wire rfs_pkg::rfs_regv_t  releaseSet,
  input  wire logic                powerupGoodGateCfg,
  input  wire logic [3:0]          faultTallyLimitDefault,
  input  wire logic [3:0]          timerSelDefault,
  input  wire rfs_pkg::rfs_regv_t  overcurrentSkipDefault,
  input  wire rfs_pkg::rfs_regv_t  undervoltSkipDefault,
  input  wire rfs_pkg::rfs_regv_t  overvoltSkipDefault,
  input  wire logic                lin2PinCtrl,
  output rfs_pkg::rfs_regv_t       regEnable,
  output logic                     powerDownReq,
  output logic                     powerUpHold,
  output logic                     powerUpAbort
);
  import rfs_pkg::*;
  typedef enum logic [1:0] {REL_IDLE, REL_WAIT, REL_DONE, REL_FAIL} rfs_rel_e;
  rfs_rel_e                 relState;
  logic [11:0]              divCnt;
  logic [NFT-1:0][NREG-1:0] rawF, rawPrev, skip, keep, latch, mask;
  rfs_regv_t                reen, swEn, effIlim, effUv, effOv, effNow, effPrev;
  rfs_regv_t                ilimHeld, kill, faultOff, stuck, clearStuck, swOn;
  logic [NREG-1:0][3:0]     ilimCnt, recCnt;
  logic [3:0]               tally, next_tally, limit, tsel;
  logic [FT_CW-1:0]         ftCnt, ftLen;
  logic [4:0]               pgCnt;
  logic                     tick, faultEvt, tallyTrip, timerTrip, ftFired;
  logic                     allGood, released, abortNow, shut, wrHit;

  assign wrHit = link.wr;
  assign rawF  = {ovIn, uvIn, ilimIn};
  // base tick keeps every long wait in a small counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCnt <= 12'h000;
      tick   <= 1'b0;
    end else begin
      tick   <= (divCnt == 12'(TICK_CYC - 1));
      divCnt <= (divCnt == 12'(TICK_CYC - 1)) ? 12'h000 : divCnt + 12'h001;
    end
  end

  // ov/uv watched only after the reset release point
  assign released = (relState == REL_DONE);
  assign effIlim  = rawF[FT_ILIM] & ~skip[FT_ILIM];
  assign effUv    = rawF[FT_UV] & ~skip[FT_UV] & {NREG{released}};
  assign effOv    = rawF[FT_OV] & ~skip[FT_OV] & {NREG{released}};
  assign effNow   = effIlim | effUv | effOv;
  assign kill     = (ilimHeld & ~keep[FT_ILIM]) | (effUv & ~keep[FT_UV]) | (effOv & ~keep[FT_OV]);
  assign faultEvt = |(effNow & ~effPrev);
  assign swOn     = lin2PinCtrl ? ((swEn & ~(NREG'(1) << LIN2_IDX)) | (NREG'(link.secondLinearEnablePin) << LIN2_IDX))
                                : swEn;

  always_comb begin
    clearStuck = '0;
    if (wrHit && link.addr == REG_SWEN && sysOn) begin
      clearStuck = link.wdata[NREG-1:0] & ~swEn;
      if (lin2PinCtrl) clearStuck[LIN2_IDX] = 1'b1;
    end
  end

  // per-regulator disable, ilim removal debounce and recovery
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ilimHeld <= '0;
      ilimCnt  <= '0;
      faultOff <= '0;
      stuck    <= '0;
      recCnt   <= '0;
    end else begin
      for (int i = 0; i < NREG; i++) begin
        // a fresh stuck event outranks a restart in the same cycle
        if (clearStuck[i] && !kill[i]) stuck[i] <= 1'b0;
        if (effIlim[i]) begin
          ilimHeld[i] <= 1'b1;
          ilimCnt[i]  <= 4'h0;
        end else if (ilimHeld[i] && tick) begin
          ilimCnt[i]  <= ilimCnt[i] + 4'h1;
          if (ilimCnt[i] == 4'(ILIM_DB_TICKS - 1)) ilimHeld[i] <= 1'b0;
        end
        if (kill[i]) begin
          faultOff[i] <= 1'b1;
          recCnt[i]   <= 4'h0;
        end else if (faultOff[i] && !reen[i]) begin
          faultOff[i] <= 1'b0;
          stuck[i]    <= 1'b1;
        end else if (faultOff[i] && tick) begin
          recCnt[i]   <= recCnt[i] + 4'h1;
          if (recCnt[i] == 4'(REEN_TICKS - 1)) faultOff[i] <= 1'b0;
        end
      end
    end
  end

  always_comb begin
    next_tally = tally;
    if (wrHit && link.addr == REG_TALLY && link.wdata[3:0] == 4'h0) next_tally = 4'h0;
  end
  assign tallyTrip = faultEvt && (next_tally == limit) && (limit != 4'h0);

  // a fault in the clearing cycle counts from zero
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tally   <= 4'h0;
      effPrev <= '0;
    end else begin
      effPrev <= effNow;
      if (faultEvt && next_tally != limit) tally <= next_tally + 4'h1;
      else tally <= next_tally;
    end
  end

  assign ftLen     = (tsel == TSEL_LONG) ? FT_CW'(FT_LONG_MS * FT_BASE_TICKS)
                                         : FT_CW'(FT_BASE_TICKS) << tsel;
  assign timerTrip = tick && !ftFired && (tsel <= TSEL_LONG) && (ftCnt == ftLen - FT_CW'(1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ftCnt   <= '0;
      ftFired <= 1'b0;
    end else if (!(|effNow)) begin
      ftCnt   <= '0;
      ftFired <= 1'b0;
    end else if (tick && !ftFired) begin
      ftCnt   <= ftCnt + FT_CW'(1);
      ftFired <= timerTrip;
    end
  end
  // reset release gate
  assign allGood  = &(pgIn | ~releaseSet);
  assign abortNow = (relState == REL_WAIT) && !allGood && tick && (pgCnt == 5'(PG_WAIT_TICKS - 1));

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      relState <= REL_IDLE;
      pgCnt    <= 5'h00;
    end else if (seqStart) begin
      relState <= REL_IDLE;
      pgCnt    <= 5'h00;
    end else begin
      unique case (relState)
        REL_IDLE: if (atReleasePoint) begin
          pgCnt <= 5'h00;
          if (!powerupGoodGateCfg || allGood) relState <= REL_DONE;
          else relState <= REL_WAIT;
        end
        REL_WAIT: begin
          if (allGood) relState <= REL_DONE;
          else if (abortNow) relState <= REL_FAIL;
          else if (tick) pgCnt <= pgCnt + 5'h01;
        end
        REL_DONE, REL_FAIL: relState <= relState;
      endcase
    end
  end
  assign powerUpHold = atReleasePoint && !released;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shut          <= 1'b0;
      powerDownReq  <= 1'b0;
      powerUpAbort  <= 1'b0;
      regEnable     <= '0;
      link.hostResetOutN <= 1'b0;
      link.powerGoodPin  <= 1'b0;
      link.irqOutN       <= 1'b1;
    end else begin
      powerDownReq  <= tallyTrip | timerTrip | abortNow;
      powerUpAbort  <= abortNow;
      if (tallyTrip || timerTrip || abortNow) shut <= 1'b1;
      else if (seqStart) shut <= 1'b0;
      // a faulted regulator drops out alone so later slots still come up; shut masks every slot
      regEnable     <= seqEnable & swOn & ~faultOff & ~stuck & {NREG{~shut}};
      link.hostResetOutN <= released;
      link.powerGoodPin  <= released && !(|(effUv | effOv));
      link.irqOutN       <= !(|(latch & ~mask));
    end
  end
  // register file
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      limit   <= 4'h0;
      tsel    <= TSEL_OFF;
      reen    <= REEN_RST;
      swEn    <= SWEN_RST;
      skip    <= '0;
      keep    <= {NFT{KEEP_RST}};
      mask    <= {NFT{MASK_RST}};
      latch   <= '0;
      rawPrev <= '0;
    end else begin
      rawPrev <= rawF;
      if (seqStart) begin
        limit <= faultTallyLimitDefault;
        tsel  <= timerSelDefault;
        skip  <= {overvoltSkipDefault, undervoltSkipDefault, overcurrentSkipDefault};
      end else if (wrHit) begin
        if (link.addr == REG_CTRL) begin
          limit <= link.wdata[CTRL_LIM_LSB +: 4];
          if (sysOn) tsel <= link.wdata[CTRL_TSEL_LSB +: 4];
        end
        if (link.addr == REG_REEN) reen <= link.wdata[NREG-1:0];
        if (link.addr == REG_SWEN) swEn <= link.wdata[NREG-1:0];
      end
      for (int t = 0; t < NFT; t++) begin
        if (wrHit && link.addr == REG_SKIP0 + AW'(t)) skip[t] <= link.wdata[NREG-1:0];
        if (wrHit && link.addr == REG_KEEP0 + AW'(t)) keep[t] <= link.wdata[NREG-1:0];
        if (wrHit && link.addr == REG_MASK0 + AW'(t)) mask[t] <= link.wdata[NREG-1:0];
        // new edge wins over the write-one clear
        if (wrHit && link.addr == REG_LATCH0 + AW'(t))
          latch[t] <= (latch[t] & ~link.wdata[NREG-1:0]) | (rawF[t] & ~rawPrev[t]);
        else
          latch[t] <= latch[t] | (rawF[t] & ~rawPrev[t]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      link.rdata <= '0;
    end else if (link.rd) begin
      link.rdata <= '0;
      if (link.addr == REG_CTRL) link.rdata <= {8'h00, tsel, limit};
      if (link.addr == REG_TALLY) link.rdata <= {12'h000, tally};
      if (link.addr == REG_REEN) link.rdata <= {5'h00, reen};
      if (link.addr == REG_SWEN) link.rdata <= {5'h00, swEn};
      if (link.addr == REG_STATUS) link.rdata <= {5'h00, regEnable};
      for (int t = 0; t < NFT; t++) begin
        if (link.addr == REG_SKIP0 + AW'(t)) link.rdata <= {5'h00, skip[t]};
        if (link.addr == REG_KEEP0 + AW'(t)) link.rdata <= {5'h00, keep[t]};
        if (link.addr == REG_LATCH0 + AW'(t)) link.rdata <= {5'h00, latch[t]};
        if (link.addr == REG_MASK0 + AW'(t)) link.rdata <= {5'h00, mask[t]};
      end
    end
  end
endmodule : rfs_device

// ### rfs_host.sv
// host end: register master with restart and tally-clear helpers
`timescale 1ns/1ps
module rfs_host (
  input  wire logic           ref_clk,
  input  wire logic           arst_n,
  rfs_if.host                 link,
  input  wire logic [2:0]     swAddr,
  input  wire logic [15:0]    swWdata,
  input  wire logic           swWr,
  input  wire logic           swRd,
  output logic [15:0]         swRdata
);
  import rfs_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_RD, H_CAPT, H_WR2} rfs_hst_e;

  rfs_hst_e        state;
  logic [1:0]      op;
  logic [AW-1:0]   tgtAddr;
  logic [DW-1:0]   tgtData;
  logic [DW-1:0]   bitMask;
  logic            pinLevel;
  logic            cmdGo;

  assign cmdGo   = swWr && swAddr == H_CMD && state == H_IDLE;
  assign bitMask = DW'(1) << tgtAddr[3:0];
  assign link.secondLinearEnablePin = pinLevel;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state      <= H_IDLE;
      op         <= HOP_WRITE;
      tgtAddr    <= '0;
      tgtData    <= '0;
      pinLevel   <= 1'b0;
      link.addr  <= '0;
      link.wdata <= '0;
      link.wr    <= 1'b0;
      link.rd    <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      if (swWr && swAddr == H_ADDR && state == H_IDLE) tgtAddr <= swWdata[AW-1:0];
      if (swWr && swAddr == H_DATA && state == H_IDLE) tgtData <= swWdata;
      if (swWr && swAddr == H_PIN) pinLevel <= swWdata[0];
      unique case (state)
        H_IDLE: if (cmdGo) begin
          op <= swWdata[1:0];
          unique case (swWdata[1:0])
            HOP_WRITE: begin
              // timer select only sticks while the system is on
              link.wr    <= 1'b1;
              link.addr  <= tgtAddr;
              link.wdata <= tgtData;
            end
            HOP_READ: begin
              link.rd   <= 1'b1;
              link.addr <= tgtAddr;
              state     <= H_RD;
            end
            HOP_RESTART: begin
              link.rd   <= 1'b1;
              link.addr <= REG_SWEN;
              state     <= H_RD;
            end
            HOP_CLRTALLY: begin
              link.rd   <= 1'b1;
              link.addr <= REG_TALLY;
              state     <= H_RD;
            end
          endcase
        end
        H_RD: state <= H_CAPT;
        H_CAPT: begin
          tgtData <= link.rdata;
          state   <= H_IDLE;
          if (op == HOP_CLRTALLY) begin
            link.wr    <= 1'b1;
            link.wdata <= '0;
          end else if (op == HOP_RESTART) begin
            link.wr    <= 1'b1;
            link.wdata <= link.rdata & ~bitMask;
            state      <= H_WR2;
          end
        end
        H_WR2: begin
          link.wr    <= 1'b1;
          link.wdata <= tgtData | bitMask;
          state      <= H_IDLE;
        end
        default: state <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      swRdata <= '0;
    end else if (swRd) begin
      unique case (swAddr)
        H_ADDR:  swRdata <= {8'h00, tgtAddr};
        H_DATA:  swRdata <= tgtData;
        H_STAT:  swRdata <= {12'h000, link.powerGoodPin, link.hostResetOutN, link.irqOutN, state != H_IDLE};
        H_PIN:   swRdata <= {15'h0000, pinLevel};
        default: swRdata <= '0;
      endcase
    end
  end
endmodule : rfs_host

// ### rfs_if.sv
// link between the supervisor and its host processor
`timescale 1ns/1ps
interface rfs_if;
  import rfs_pkg::*;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  logic          wr;
  logic          rd;
  logic          hostResetOutN;
  logic          powerGoodPin;
  logic          irqOutN;
  logic          secondLinearEnablePin;
  modport dev (input addr, wdata, wr, rd, secondLinearEnablePin,
               output rdata, hostResetOutN, powerGoodPin, irqOutN);
  modport host (output addr, wdata, wr, rd, secondLinearEnablePin,
                input rdata, hostResetOutN, powerGoodPin, irqOutN);
endinterface : rfs_if

// ### rfs_monitor.sv
// checker on the supervisor-host link signals
`timescale 1ns/1ps
module rfs_monitor (
  input wire logic                   ref_clk,
  input wire logic                   arst_n,
  input wire logic [rfs_pkg::AW-1:0] addr,
  input wire logic [rfs_pkg::DW-1:0] wdata,
  input wire logic [rfs_pkg::DW-1:0] rdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic                   hostResetOutN,
  input wire logic                   powerGoodPin,
  input wire logic                   irqOutN
);
  import rfs_pkg::*;
  logic irqWrite;
  // only a latch clear or a mask write may let the interrupt line go high
  assign irqWrite = wr && addr >= REG_LATCH0 && addr <= 8'h0f;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  property p_excl; !(wr && rd); endproperty
  a_excl: assert property (p_excl) else $error("write and read strobes together");
  property p_rd_gap; rd |=> !rd && !wr; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("bus busy right after a read");
  property p_tally_rd; rd && addr == REG_TALLY |=> rdata[15:4] == 12'h000; endproperty
  a_tally_rd: assert property (p_tally_rd) else $error("tally wider than four bits");
  property p_status_rd; rd && addr == REG_STATUS |=> rdata[15:11] == 5'h00; endproperty
  a_status_rd: assert property (p_status_rd) else $error("status upper bits set");
  property p_tally_wr;
    wr && addr == REG_TALLY |-> wdata == 16'h0000 && $past(rd, 2) && $past(addr, 2) == REG_TALLY;
  endproperty
  a_tally_wr: assert property (p_tally_wr) else $error("tally written without read first");
  sequence s_swen_wr; wr && addr == REG_SWEN; endsequence
  property p_restart;
    s_swen_wr ##1 s_swen_wr |-> $countones(wdata ^ $past(wdata)) == 1 && (wdata & ~$past(wdata)) != 16'h0000;
  endproperty
  a_restart: assert property (p_restart) else $error("restart is not a single bit off then on");
  property p_pg; powerGoodPin |-> hostResetOutN || $past(hostResetOutN); endproperty
  a_pg: assert property (p_pg) else $error("power good while host reset held");
  property p_irq; $rose(irqOutN) |-> $past(irqWrite) || $past(irqWrite, 2); endproperty
  a_irq: assert property (p_irq) else $error("interrupt dropped without a clear");
  c_tally: cover property (rd && addr == REG_TALLY ##1 rdata[3:0] != 4'h0);
  c_irq: cover property ($fell(irqOutN));
  c_rel: cover property ($rose(hostResetOutN));
endmodule : rfs_monitor

// ### rfs_pkg.sv
// shared constants and types for the regulator fault supervisor
package rfs_pkg;
  localparam int NREG       = 11;
  localparam int NFT        = 3;
  localparam int FT_ILIM    = 0;
  localparam int FT_UV      = 1;
  localparam int FT_OV      = 2;
  localparam int LIN2_IDX   = 8;
  localparam int AW         = 8;
  localparam int DW         = 16;
  localparam int CLK_KHZ    = 25000;
  localparam int TICK_US    = 100;
  localparam int TICK_CYC   = (TICK_US * CLK_KHZ + 999) / 1000;
  localparam int REEN_US    = 500;
  localparam int ILIM_DB_US = 1000;
  localparam int PG_WAIT_US = 2000;
  localparam int FT_BASE_US = 1000;
  localparam int FT_LONG_MS = 2056;
  localparam int REEN_TICKS    = (REEN_US + TICK_US - 1) / TICK_US;
  localparam int ILIM_DB_TICKS = (ILIM_DB_US + TICK_US - 1) / TICK_US;
  localparam int PG_WAIT_TICKS = PG_WAIT_US / TICK_US;
  localparam int FT_BASE_TICKS = FT_BASE_US / TICK_US;
  localparam int FT_CW      = 15;
  localparam logic [3:0] TSEL_LONG = 4'hb;
  localparam logic [3:0] TSEL_OFF  = 4'hf;
  localparam logic [AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [AW-1:0] REG_TALLY  = 8'h01;
  localparam logic [AW-1:0] REG_REEN   = 8'h02;
  localparam logic [AW-1:0] REG_SWEN   = 8'h03;
  localparam logic [AW-1:0] REG_SKIP0  = 8'h04;
  localparam logic [AW-1:0] REG_KEEP0  = 8'h07;
  localparam logic [AW-1:0] REG_LATCH0 = 8'h0a;
  localparam logic [AW-1:0] REG_MASK0  = 8'h0d;
  localparam logic [AW-1:0] REG_STATUS = 8'h10;
  localparam int CTRL_LIM_LSB  = 0;
  localparam int CTRL_TSEL_LSB = 4;
  localparam logic [NREG-1:0] SWEN_RST = 11'h7ff;
  localparam logic [NREG-1:0] REEN_RST = 11'h000;
  localparam logic [NREG-1:0] KEEP_RST = 11'h000;
  localparam logic [NREG-1:0] MASK_RST = 11'h000;
  localparam logic [2:0] H_ADDR = 3'h0;
  localparam logic [2:0] H_DATA = 3'h1;
  localparam logic [2:0] H_CMD  = 3'h2;
  localparam logic [2:0] H_STAT = 3'h3;
  localparam logic [2:0] H_PIN  = 3'h4;
  localparam logic [1:0] HOP_WRITE    = 2'h0;
  localparam logic [1:0] HOP_READ     = 2'h1;
  localparam logic [1:0] HOP_RESTART  = 2'h2;
  localparam logic [1:0] HOP_CLRTALLY = 2'h3;
  typedef logic [NREG-1:0] rfs_regv_t;
endpackage : rfs_pkg

// ### testbench.sv
// self-checking bench: supervisor and host end joined by the link
`timescale 1ns/1ps
module testbench;
  import rfs_pkg::*;
  localparam int LIMIT = 95000;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        seqStart = 1'b0;
  logic        atReleasePoint = 1'b0;
  logic        gateCfg = 1'b0;
  logic        sysOn = 1'b1;
  logic        lin2 = 1'b0;
  logic        powerUpAbort;
  int          abortCount = 0;
  logic [3:0]  limDef = 4'h2;
  logic [3:0]  tselDef = 4'hf;
  logic [2:0]  swAddr = 3'h0;
  logic [15:0] swWdata = 16'h0000;
  logic        swWr = 1'b0;
  logic        swRd = 1'b0;
  logic [15:0] swRdata;
  rfs_regv_t   ovIn = 11'h000;
  rfs_regv_t   uvIn = 11'h000;
  rfs_regv_t   ilimIn = 11'h000;
  rfs_regv_t   pgIn = 11'h000;
  rfs_regv_t   releaseSet = 11'h000;
  rfs_regv_t   ocSkipDef = 11'h040;
  rfs_regv_t   regEnable;
  rfs_regv_t   snapEn;
  logic        powerDownReq;
  logic        powerUpHold;
  logic        snapHold;
  logic        snapRst;
  logic        snapPg;
  logic        snapIrq;
  int          errors = 0;
  int          checks = 0;
  int          cycles = 0;
  int          pdCount = 0;
  int          base;

  rfs_if rfs_if_inst ();
  rfs_device rfs_device_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(rfs_if_inst),
    .ovIn(ovIn), .uvIn(uvIn), .ilimIn(ilimIn), .pgIn(pgIn), .seqStart(seqStart), .sysOn(sysOn),
    .seqEnable(11'h7ff), .atReleasePoint(atReleasePoint), .releaseSet(releaseSet),
    .powerupGoodGateCfg(gateCfg), .faultTallyLimitDefault(limDef), .timerSelDefault(tselDef),
    .overcurrentSkipDefault(ocSkipDef), .undervoltSkipDefault(11'h000), .overvoltSkipDefault(11'h000),
    .lin2PinCtrl(lin2), .regEnable(regEnable), .powerDownReq(powerDownReq), .powerUpHold(powerUpHold),
    .powerUpAbort(powerUpAbort));
  rfs_host rfs_host_inst (.ref_clk(ref_clk), .arst_n(arst_n), .link(rfs_if_inst), .swAddr(swAddr),
    .swWdata(swWdata), .swWr(swWr), .swRd(swRd), .swRdata(swRdata));
  rfs_monitor rfs_monitor_inst (.ref_clk(ref_clk), .arst_n(arst_n), .addr(rfs_if_inst.addr),
    .wdata(rfs_if_inst.wdata), .rdata(rfs_if_inst.rdata), .wr(rfs_if_inst.wr), .rd(rfs_if_inst.rd),
    .hostResetOutN(rfs_if_inst.hostResetOutN), .powerGoodPin(rfs_if_inst.powerGoodPin),
    .irqOutN(rfs_if_inst.irqOutN));

  always #20 ref_clk = ~ref_clk;
  // snapshots taken mid-cycle so checks never race the flops
  always @(negedge ref_clk) begin
    snapEn = regEnable;
    snapHold = powerUpHold;
    snapRst = rfs_if_inst.hostResetOutN;
    snapPg = rfs_if_inst.powerGoodPin;
    snapIrq = rfs_if_inst.irqOutN;
  end
  always @(posedge ref_clk) begin
    if (powerDownReq === 1'b1) begin
      pdCount <= pdCount + 1;
    end
    if (powerUpAbort === 1'b1) begin
      abortCount <= abortCount + 1;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // swWr stays high across the three host writes; host ignores commands while busy
  task automatic cmd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] op);
    swWr <= 1'b1;
    swAddr <= H_ADDR;
    swWdata <= {8'h00, a};
    @(posedge ref_clk);
    swAddr <= H_DATA;
    swWdata <= d;
    @(posedge ref_clk);
    swAddr <= H_CMD;
    swWdata <= {14'h0000, op};
    @(posedge ref_clk);
    swWr <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask : cmd

  task automatic regWr(input logic [7:0] a, input logic [15:0] d);
    cmd(a, d, HOP_WRITE);
  endtask : regWr

  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    cmd(a, 16'h0000, HOP_READ);
    swAddr <= H_DATA;
    swRd <= 1'b1;
    @(posedge ref_clk);
    swRd <= 1'b0;
    @(negedge ref_clk);
    d = swRdata;
    @(posedge ref_clk);
    check(d, e);
  endtask : rdChk

  task automatic fault(input int k, input rfs_regv_t m, input int n);
    case (k)
      FT_ILIM: ilimIn <= m;
      FT_UV: uvIn <= m;
      default: ovIn <= m;
    endcase
    repeat (n) @(posedge ref_clk);
  endtask : fault

  task automatic powerUp(input logic gate);
    gateCfg <= gate;
    seqStart <= 1'b1;
    atReleasePoint <= 1'b0;
    @(posedge ref_clk);
    seqStart <= 1'b0;
    atReleasePoint <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask : powerUp

  task automatic clrLatch();
    for (int i = 0; i < 3; i++) begin
      regWr(REG_LATCH0 + 8'(i), 16'h07ff);
    end
  endtask : clrLatch

  task automatic t_start();
    rdChk(REG_CTRL, 16'h00f0);
    rdChk(REG_SWEN, 16'h07ff);
    check({15'h0000, snapRst}, 16'h0000);
    powerUp(1'b0);
    check({15'h0000, snapRst}, 16'h0001);
    rdChk(REG_CTRL, 16'h00f2);
    rdChk(REG_SKIP0, 16'h0040);
    check({15'h0000, snapIrq}, 16'h0001);
    $display("test start done");
  endtask : t_start

  task automatic t_skip();
    regWr(8'h06, 16'h0004);
    fault(FT_OV, 11'h004, 8);
    check({15'h0000, snapPg}, 16'h0001);
    fault(FT_OV, 11'h000, 8);
    check({5'h00, snapEn}, 16'h07ff);
    rdChk(REG_TALLY, 16'h0000);
    check({15'h0000, snapIrq}, 16'h0000);
    regWr(8'h0c, 16'h0004);
    check({15'h0000, snapIrq}, 16'h0001);
    regWr(8'h0f, 16'h0004);
    fault(FT_OV, 11'h004, 8);
    fault(FT_OV, 11'h000, 8);
    check({15'h0000, snapIrq}, 16'h0001);
    $display("test skip done");
  endtask : t_skip

  task automatic t_recover();
    regWr(REG_REEN, 16'h0010);
    fault(FT_ILIM, 11'h018, 8);
    check({14'h0000, snapEn[4:3]}, 16'h0000);
    fault(FT_ILIM, 11'h000, 4 * TICK_CYC);
    check({14'h0000, snapEn[4:3]}, 16'h0000);
    repeat (13 * TICK_CYC) @(posedge ref_clk);
    check({14'h0000, snapEn[4:3]}, 16'h0002);
    cmd(8'h03, 16'h0000, HOP_RESTART);
    repeat (4) @(posedge ref_clk);
    check({14'h0000, snapEn[4:3]}, 16'h0003);
    $display("test recover done");
  endtask : t_recover

  task automatic t_tally();
    regWr(REG_KEEP0, 16'h0087);
    cmd(8'h00, 16'h0000, HOP_CLRTALLY);
    rdChk(REG_TALLY, 16'h0000);
    fault(FT_ILIM, 11'h001, 8);
    rdChk(REG_TALLY, 16'h0001);
    fault(FT_ILIM, 11'h003, 8);
    base = pdCount;
    fault(FT_ILIM, 11'h007, 8);
    check(16'(pdCount - base), 16'h0001);
    rdChk(REG_TALLY, 16'h0002);
    cmd(8'h00, 16'h0000, HOP_CLRTALLY);
    rdChk(REG_TALLY, 16'h0000);
    regWr(REG_CTRL, 16'h00f0);
    fault(FT_ILIM, 11'h087, 8);
    check(16'(pdCount - base), 16'h0001);
    rdChk(REG_TALLY, 16'h0000);
    fault(FT_ILIM, 11'h000, 8);
    $display("test tally done");
  endtask : t_tally

  task automatic t_gate();
    clrLatch();
    releaseSet <= 11'h003;
    pgIn <= 11'h001;
    limDef <= 4'h3;
    tselDef <= 4'h1;
    ocSkipDef <= 11'h001;
    powerUp(1'b1);
    check({15'h0000, snapRst}, 16'h0000);
    check({15'h0000, snapHold}, 16'h0001);
    pgIn <= 11'h003;
    repeat (4) @(posedge ref_clk);
    check({15'h0000, snapRst}, 16'h0001);
    rdChk(REG_CTRL, 16'h0013);
    rdChk(REG_SKIP0, 16'h0001);
    // timer select must not move while the system is off
    sysOn <= 1'b0;
    regWr(REG_CTRL, 16'h0053);
    rdChk(REG_CTRL, 16'h0013);
    sysOn <= 1'b1;
    check(16'(abortCount), 16'h0000);
    // second linear under pin control: stuck, then any enable write while the system is on recovers it
    lin2 <= 1'b1;
    swAddr <= H_PIN;
    swWdata <= 16'h0001;
    swWr <= 1'b1;
    @(posedge ref_clk);
    swWr <= 1'b0;
    fault(FT_UV, 11'h100, 8);
    fault(FT_UV, 11'h000, 8);
    check({15'h0000, snapEn[8]}, 16'h0000);
    regWr(REG_SWEN, 16'h07ff);
    check({15'h0000, snapEn[8]}, 16'h0001);
    lin2 <= 1'b0;
    $display("test gate done");
  endtask : t_gate

  task automatic t_timer();
    regWr(REG_CTRL, 16'h000f);
    fault(FT_UV, 11'h020, 3 * TICK_CYC);
    fault(FT_UV, 11'h000, TICK_CYC);
    base = pdCount;
    // restarted timer must not trip although the fault has lasted eleven ticks overall
    fault(FT_UV, 11'h020, 8 * TICK_CYC);
    check(16'(pdCount - base), 16'h0000);
    repeat (4 * TICK_CYC) @(posedge ref_clk);
    check(16'(pdCount - base), 16'h0001);
    check({5'h00, snapEn}, 16'h0000);
    $display("test timer done");
  endtask : t_timer

  initial begin
    repeat (5) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    t_start();
    t_skip();
    t_recover();
    t_tally();
    t_gate();
    t_timer();
    tally_and_finish();
  end
endmodule : testbench
